// >>> core/usb_out_desc_store.sv
// Output endpoint descriptor store with the per-packet update engine.
//
// The implementer's own choice: register access over APB.
`timescale 1ns/10ps

// Contract
// [R01] Three endpoint descriptors, each X/Y plus status.
// [R02] Endpoints one to three stored; endpoint zero excluded.
// [R03] Config at 00, X base 01, X count 02.
// [R04] Y base 05, Y count 06, size 07.
// [R05] Config bytes at FF08, FF10, FF18.
// [R06] Completion interrupt only when enable bit set.
// [R07] Stall resets zero, answers STALL, firmware clears.
// [R08] Single X buffer unless double buffering; toggle selects.
// [R09] Toggle bit tracks DATA0/DATA1 sequence.
// [R10] Firmware keeps isochronous bit cleared.
// [R11] Buffer manager ignores endpoint when disabled.
// [R12] Base byte plus three zeros gives address.
// [R13] Engine never rewrites buffer base addresses.
// [R14] Counts 0..64; larger values are firmware error.
// [R15] NAK flag clear means buffer ready.
// [R16] NAK flag set answers host with NAK.
// [R17] Size 0..64 shared by X and Y.
// [R18] Store count, set NAK, flip toggle.
// [R19] Firmware writes reserved config bits zero.
module usb_out_desc_store
  import usb_out_desc_pkg::*;
(
  // Clock and reset
  input  wire logic       clk,
  input  wire logic       sys_rst,
  // Descriptor access and completion
  endpoint_link_if.store  link,
  // Received OUT packet, one-cycle strobe
  input  wire logic       pkt_valid,
  input  wire logic [1:0] pkt_ep,
  input  wire logic       pkt_data1,
  input  wire logic [6:0] pkt_len,
  // Decision for that packet
  output logic            hs_valid,
  output handshake_t      hs_code,
  output logic [10:0]     hs_buf_addr,
  output logic            hs_store
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  // Whole descriptor image plus every registered output, held as one flop set.
  // Byte 8*(n-1)+k of the image is entry k of endpoint n.
  typedef struct packed {
    logic [DESC_BYTES-1:0][7:0] mem;
    logic                       ack;
    logic [7:0]                 rdata;
    logic [2:0]                 done;
    logic                       hs_valid;
    handshake_t                 hs_code;
    logic [10:0]                buf_addr;
    logic                       store;
  } state_t;

  // Present state and the value it takes at the next edge.
  state_t st;
  state_t next_st;

  // ----------------------------------------------------------------
  // Address helpers
  // ----------------------------------------------------------------
  // Maps a bus address onto a descriptor byte; hit is low outside the block.
  // The hit flag sits in bit 5 and the byte index below it.
  function automatic logic [5:0] desc_index(input logic [15:0] a);
    logic [15:0] rel;
    rel = a - DESC_BASE_ADDR;
    if (a >= DESC_BASE_ADDR && rel < 16'(DESC_BYTES))
      desc_index = {1'b1, rel[4:0]};
    else
      desc_index = 6'h00;
  endfunction

  // Byte at a given offset within an endpoint's descriptor.
  // Only meaningful for endpoints one to three; callers screen endpoint zero.
  function automatic logic [4:0] ep_byte(input logic [1:0] ep, input logic [2:0] off);
    ep_byte = {ep - 2'h1, off};
  endfunction

  // Chooses the Y entry only when double buffering points at the Y buffer.
  function automatic logic [2:0] pick_offset(input logic       use_y,
                                             input logic [2:0] y_off,
                                             input logic [2:0] x_off);
    pick_offset = use_y ? y_off : x_off;
  endfunction

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  // The packet engine has priority; a firmware access waiting on it
  // simply sees its ack one cycle later, so no update is ever lost.
  always_comb
  begin
    // Scratch values, each given a value at the top so no latch forms.
    logic [7:0] cfg;
    logic       sel_y;
    logic [4:0] cnt_i;
    logic [4:0] bas_i;
    logic [5:0] hit;
    cfg     = 8'h00;
    sel_y   = 1'b0;
    cnt_i   = 5'h00;
    bas_i   = 5'h00;
    hit     = 6'h00;
    // Pulses fall back to zero each cycle; held outputs keep their value.
    next_st = st;
    next_st.ack      = 1'b0;
    next_st.done     = 3'h0;
    next_st.hs_valid = 1'b0;
    next_st.store    = 1'b0;
    if (pkt_valid)
    begin
      // Every packet gets an answer; the code defaults to no reply.
      next_st.hs_valid = 1'b1;
      next_st.hs_code  = HS_NONE;
      next_st.buf_addr = 11'h000;
      // [R02] endpoint zero excluded
      if (pkt_ep != 2'h0)
      begin
        // [R03] config byte offset
        cfg   = st.mem[ep_byte(pkt_ep, OFF_CONFIG)];
        // Without double buffering the toggle never moves the buffer.
        // [R08] buffer selection
        sel_y = cfg[CFG_DOUBLE_BUFFER_ENABLE] & cfg[CFG_TOGGLE];
        // [R04] Y entries offsets
        cnt_i = ep_byte(pkt_ep, pick_offset(sel_y, OFF_YCOUNT, OFF_XCOUNT));
        bas_i = ep_byte(pkt_ep, pick_offset(sel_y, OFF_YBASE, OFF_XBASE));
        // [R12] form start address
        next_st.buf_addr = {st.mem[bas_i], 3'b000};
        // [R11] disabled endpoint ignored
        if (!cfg[CFG_BM_EN])
          next_st.hs_code = HS_NONE;
        // [R07] stall handshake
        else if (cfg[CFG_STALL])
          next_st.hs_code = HS_STALL;
        // [R16] full buffer NAKs
        else if (st.mem[cnt_i][COUNT_NAK])
          next_st.hs_code = HS_NAK;
        // A repeat of the last packet is acknowledged but leaves the descriptor alone.
        // [R09] repeated packet discarded
        else if (pkt_data1 != cfg[CFG_TOGGLE])
          next_st.hs_code = HS_ACK;
        else
        begin
          // The length is not held against the size byte; firmware sizes the buffers.
          // [R15] empty buffer accepts
          next_st.hs_code = HS_ACK;
          next_st.store   = 1'b1;
          // [R18] count, NAK, toggle
          // [R14] length stored as count
          next_st.mem[cnt_i] = {1'b1, pkt_len};
          // [R09] toggle advances on store
          next_st.mem[ep_byte(pkt_ep, OFF_CONFIG)][CFG_TOGGLE] = ~cfg[CFG_TOGGLE];
          // [R06] gated completion event
          next_st.done[pkt_ep - 2'h1] = cfg[CFG_IRQ_EN];
        end
      end
    end
    // A request seen while ack stands is the one just served, so it is skipped.
    else if (link.req && !st.ack)
    begin
      // Unmapped addresses still answer, so a firmware access never hangs.
      // [R05] decode descriptor window
      hit = desc_index(link.addr);
      next_st.ack   = 1'b1;
      next_st.rdata = hit[5] ? st.mem[hit[4:0]] : 8'h00;
      // [R13] only firmware writes bases
      // [R17] size byte kept as written
      if (link.we && hit[5])
        next_st.mem[hit[4:0]] = link.wdata;
    end
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  // One flop set for all state keeps reset and update in one place.
  // The clear brings every descriptor byte to zero, stall included.
  // [R07] stall bit resets zero
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      st <= '0;
    end
    else
    begin
      st <= next_st;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  // [R01] descriptor contents exposed
  assign link.ack    = st.ack;
  assign link.rdata  = st.rdata;
  assign link.done   = st.done;

  // Packet answer; hs_valid and hs_store are one-cycle pulses, while hs_code and
  // hs_buf_addr hold until the next packet.
  assign hs_valid    = st.hs_valid;
  assign hs_code     = st.hs_code;
  assign hs_buf_addr = st.buf_addr;
  assign hs_store    = st.store;

endmodule

// >>> core/usb_out_desc_pkg.sv
// Shared constants and types for the output endpoint descriptor store and its controller.
package usb_out_desc_pkg;

  // ----------------------------------------------------------------
  // Descriptor placement
  // ----------------------------------------------------------------
  localparam logic [15:0] DESC_BASE_ADDR = 16'hff08;  // Endpoint 1 configuration byte.
  localparam int          EP_COUNT       = 3;
  localparam int          DESC_BYTES     = 8 * EP_COUNT;
  localparam logic [2:0]  OFF_CONFIG     = 3'h0;
  localparam logic [2:0]  OFF_XBASE      = 3'h1;
  localparam logic [2:0]  OFF_XCOUNT     = 3'h2;
  localparam logic [2:0]  OFF_YBASE      = 3'h5;
  localparam logic [2:0]  OFF_YCOUNT     = 3'h6;
  localparam logic [2:0]  OFF_SIZE       = 3'h7;
  localparam logic [7:0]  DESC_RESET     = 8'h00;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int CFG_IRQ_EN = 2;
  localparam int CFG_STALL  = 3;
  localparam int CFG_DOUBLE_BUFFER_ENABLE   = 4;
  localparam int CFG_TOGGLE = 5;
  localparam int CFG_ISO    = 6;
  localparam int CFG_BM_EN  = 7;
  localparam int COUNT_NAK  = 7;

  // ----------------------------------------------------------------
  // Controller registers on the APB side
  // ----------------------------------------------------------------
  localparam logic [7:0]  REG_ADDR       = 8'h00;
  localparam logic [7:0]  REG_WDATA      = 8'h04;
  localparam logic [7:0]  REG_CTRL       = 8'h08;
  localparam logic [7:0]  REG_RDATA      = 8'h0c;
  localparam logic [7:0]  REG_IRQ_STATUS = 8'h10;
  localparam logic [7:0]  REG_IRQ_MASK   = 8'h14;
  localparam int          CTRL_GO        = 0;
  localparam int          CTRL_WRITE     = 1;
  localparam int          IRQ_ACCESS     = 3;
  localparam logic [3:0]  IRQ_RESET      = 4'h0;

  // Handshake answered to the host for one OUT packet.
  typedef enum logic [1:0] {HS_NONE, HS_ACK, HS_NAK, HS_STALL} handshake_t;

endpackage

// >>> core/endpoint_link_if.sv
// Byte access and completion path between descriptor store and controller.
`timescale 1ns/10ps
interface endpoint_link_if;
  logic        req;    // Access request, held until ack.
  logic        we;     // Write when high.
  logic [15:0] addr;   // Byte address.
  logic [7:0]  wdata;
  logic [7:0]  rdata;  // Valid with ack.
  logic        ack;    // One-cycle pulse.
  logic [2:0]  done;   // Per-endpoint completion pulse.

  modport store (input req, we, addr, wdata, output rdata, ack, done);
  modport ctrl  (output req, we, addr, wdata, input rdata, ack, done);
endinterface

// >>> core/usb_desc_controller.sv
// Firmware-side controller: APB registers driving descriptor accesses and interrupts.
`timescale 1ns/10ps
module usb_desc_controller
  import usb_out_desc_pkg::*;
(
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        sys_rst,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  // Interrupt
  output logic             irq,
  // Descriptor store
  endpoint_link_if.ctrl    link
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef enum logic {ST_IDLE, ST_WAIT} phase_t;

  typedef struct packed {
    phase_t      phase;
    logic [15:0] addr;
    logic [7:0]  wdata;
    logic [7:0]  rdata;
    logic        we;
    logic        req;
    logic [3:0]  status;
    logic [3:0]  mask;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        irq;
  } state_t;

  state_t st;
  state_t next_st;

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  // Read data is captured in the setup cycle; a read of the status register
  // clears only the bits it returned, so a later event is never lost.
  always_comb
  begin
    logic       commit;
    logic [3:0] events;
    logic [3:0] clr;
    commit  = psel && penable && st.pready;
    events  = {1'b0, link.done};
    clr     = 4'h0;
    next_st = st;
    next_st.pready = psel && !penable;
    if (psel && !penable)
    begin
      next_st.pslverr = 1'b0;
      case (paddr)
        REG_ADDR:       next_st.prdata = {16'h0000, st.addr};
        REG_WDATA:      next_st.prdata = {24'h000000, st.wdata};
        REG_CTRL:       next_st.prdata = {31'h00000000, st.phase == ST_WAIT};
        REG_RDATA:      next_st.prdata = {24'h000000, st.rdata};
        REG_IRQ_STATUS: next_st.prdata = {28'h0000000, st.status};
        REG_IRQ_MASK:   next_st.prdata = {28'h0000000, st.mask};
        default:
        begin
          next_st.prdata  = 32'h00000000;
          next_st.pslverr = 1'b1;
        end
      endcase
    end
    if (commit && !pwrite && paddr == REG_IRQ_STATUS)
      clr = st.prdata[3:0];
    if (commit && pwrite)
    begin
      case (paddr)
        REG_ADDR:     next_st.addr  = pwdata[15:0];
        REG_WDATA:    next_st.wdata = pwdata[7:0];
        REG_IRQ_MASK: next_st.mask  = pwdata[3:0];
        default:      next_st.mask  = st.mask;
      endcase
    end
    // Access sequencer: a start while busy is dropped.
    case (st.phase)
      ST_IDLE:
      begin
        if (commit && pwrite && paddr == REG_CTRL && pwdata[CTRL_GO])
        begin
          next_st.we    = pwdata[CTRL_WRITE];
          next_st.req   = 1'b1;
          next_st.phase = ST_WAIT;
        end
      end
      ST_WAIT:
      begin
        if (link.ack)
        begin
          next_st.req   = 1'b0;
          next_st.rdata = link.rdata;
          next_st.phase = ST_IDLE;
          events[IRQ_ACCESS] = 1'b1;
        end
      end
      default: next_st.phase = ST_IDLE;
    endcase
    // Set wins over the read clear.
    next_st.status = (st.status & ~clr) | events;
    next_st.irq    = |(next_st.status & next_st.mask);
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      st <= '0;
    end
    else
    begin
      st <= next_st;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign prdata     = st.prdata;
  assign pready     = st.pready;
  assign pslverr    = st.pslverr;
  assign irq        = st.irq;
  assign link.req   = st.req;
  assign link.we    = st.we;
  assign link.addr  = st.addr;
  assign link.wdata = st.wdata;

endmodule

// >>> sim/usb_link_checker.sv
// Assertions on the link between the descriptor store and its controller.
`timescale 1ns/10ps
module usb_link_checker (
  // Clock and reset
  input wire logic        clk,
  input wire logic        sys_rst,
  // Link signals
  input wire logic        req,
  input wire logic        we,
  input wire logic [15:0] addr,
  input wire logic [7:0]  wdata,
  input wire logic [7:0]  rdata,
  input wire logic        ack,
  input wire logic [2:0]  done
);
  // ----------------------------------------------------------------
  // Link protocol
  // ----------------------------------------------------------------
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);

  ack_pulse_a: assert property (ack |=> !ack)
    else $error("ack stood longer than one cycle");
  ack_req_a: assert property (ack |-> req)
    else $error("ack without a request");
  req_hold_a: assert property (req && !ack |=> req && $stable(addr) && $stable(wdata))
    else $error("request changed before ack");
  req_drop_a: assert property (ack |=> !req)
    else $error("request not dropped after ack");
  ack_bound_a: assert property ($rose(req) |-> ##[1:8] ack)
    else $error("ack late");
  rdata_hold_a: assert property (!ack |-> $stable(rdata))
    else $error("read data moved without ack");
  outside_zero_a: assert property (ack && !we && (addr < 16'hff08 || addr > 16'hff1f)
    |-> rdata == 8'h00)
    else $error("unmapped descriptor read not zero");
  done_single_a: assert property ($onehot0(done))
    else $error("two completions at once");

  // Main traffic seen at least once.
  cover property (ack && we);
  cover property (ack && !we);
  cover property (done != 3'h0);
endmodule

// >>> sim/testbench.sv
// Self-checking bench for the descriptor store and its APB controller.
`timescale 1ns/10ps
module testbench
  import usb_out_desc_pkg::*;
;
  logic        clk = 1'b0;
  logic        sys_rst = 1'b1;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic [31:0] rd;
  logic        pready;
  logic        pslverr;
  logic        irq;
  logic        pkt_valid = 1'b0;
  logic [1:0]  pkt_ep = 2'h0;
  logic        pkt_data1 = 1'b0;
  logic [6:0]  pkt_len = 7'h00;
  logic        hs_valid;
  handshake_t  hs_code;
  logic [10:0] hs_buf_addr;
  logic        hs_store;
  logic [2:0]  offs [6] = '{3'h0, 3'h1, 3'h2, 3'h5, 3'h6, 3'h7};
  int          bad_count = 0;
  int          tests_run = 0;

  endpoint_link_if lk ();
  usb_out_desc_store usb_out_desc_store_inst (.clk(clk), .sys_rst(sys_rst), .link(lk),
    .pkt_valid(pkt_valid), .pkt_ep(pkt_ep), .pkt_data1(pkt_data1), .pkt_len(pkt_len),
    .hs_valid(hs_valid), .hs_code(hs_code), .hs_buf_addr(hs_buf_addr), .hs_store(hs_store));
  usb_desc_controller usb_desc_controller_inst (.clk(clk), .sys_rst(sys_rst), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .irq(irq), .link(lk));
  usb_link_checker usb_link_checker_inst (.clk(clk), .sys_rst(sys_rst), .req(lk.req),
    .we(lk.we), .addr(lk.addr), .wdata(lk.wdata), .rdata(lk.rdata), .ack(lk.ack),
    .done(lk.done));

  // Free-running 20 MHz clock.
  always #25 clk = ~clk;

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  task ck(input logic [31:0] s, input logic [31:0] e);
    tests_run++;
    if (s !== e)
    begin
      bad_count++;
      $display("Error at %0t: seen %h expected %h", $time, s, e);
    end
  endtask

  // One APB transfer; the request holds until pready is seen high.
  task ap(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do
      @(posedge clk);
    while (pready !== 1'b1);
    rd = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // Descriptor byte access through the controller, polling busy.
  task da(input logic w, input logic [15:0] a, input logic [7:0] d);
    ap(1'b1, REG_ADDR, {16'h0, a});
    ap(1'b1, REG_WDATA, {24'h0, d});
    ap(1'b1, REG_CTRL, {30'h0, w, 1'b1});
    do
      ap(1'b0, REG_CTRL, 32'h0);
    while (rd[0] !== 1'b0);
    ap(1'b0, REG_RDATA, 32'h0);
  endtask

  task dc(input logic [15:0] a, input logic [7:0] e);
    da(1'b0, a, 8'h00);
    ck(rd, {24'h0, e});
  endtask

  // One OUT packet strobe, then the answer one cycle later.
  task pk(input logic [1:0] e, input logic d1, input logic [6:0] n, input handshake_t c,
          input logic [10:0] ba, input logic st);
    @(posedge clk);
    pkt_valid <= 1'b1;
    pkt_ep <= e;
    pkt_data1 <= d1;
    pkt_len <= n;
    @(posedge clk);
    pkt_valid <= 1'b0;
    @(negedge clk);
    ck(hs_valid, 1'b1);
    ck(hs_code, c);
    ck(hs_store, st);
    if (c == HS_ACK)
      ck(hs_buf_addr, ba);
  endtask

  task results;
    $display("Comparisons %0d, mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  // ----------------------------------------------------------------
  // Tests
  // ----------------------------------------------------------------
  // Watchdog well beyond the expected run of about twelve hundred cycles.
  initial
  begin
    #400000;
    bad_count++;
    results();
  end

  // Main sequence.
  initial
  begin
    repeat (8) @(posedge clk);
    sys_rst <= 1'b0;
    dc(16'hff08, 8'h00);
    dc(16'hff20, 8'h00);
    dc(16'hff07, 8'h00);
    ap(1'b0, 8'h18, 32'h0);
    ck(pslverr, 1'b1);
    // Pattern keeps the isochronous bit clear and every count and size within 64.
    for (int e = 0; e < 3; e++)
      for (int o = 0; o < 6; o++)
        da(1'b1, 16'hff08 + 16'(8 * e + offs[o]), 8'(8'h10 + 8 * e + o));
    for (int e = 0; e < 3; e++)
      for (int o = 0; o < 6; o++)
        dc(16'hff08 + 16'(8 * e + offs[o]), 8'(8'h10 + 8 * e + o));
    // Single-buffer endpoint 1 with completion interrupt unmasked.
    ap(1'b1, REG_IRQ_MASK, 32'h1);
    da(1'b1, 16'hff08, 8'h84);
    da(1'b1, 16'hff09, 8'h10);
    da(1'b1, 16'hff0a, 8'h00);
    pk(2'd1, 1'b0, 7'd5, HS_ACK, 11'h080, 1'b1);
    dc(16'hff0a, 8'h85);
    dc(16'hff08, 8'ha4);
    dc(16'hff09, 8'h10);
    ck(irq, 1'b1);
    ap(1'b0, REG_IRQ_STATUS, 32'h0);
    ck(rd, 32'h9);
    pk(2'd1, 1'b1, 7'd3, HS_NAK, 11'h080, 1'b0);
    ck(irq, 1'b0);
    da(1'b1, 16'hff0a, 8'h00);
    pk(2'd1, 1'b0, 7'd3, HS_ACK, 11'h080, 1'b0);
    pk(2'd1, 1'b1, 7'd64, HS_ACK, 11'h080, 1'b1);
    dc(16'hff0a, 8'hc0);
    dc(16'hff08, 8'h84);
    ck(irq, 1'b1);
    ap(1'b0, REG_IRQ_STATUS, 32'h0);
    ck(rd, 32'h9);
    // Stall stays set until firmware clears it; then manager disabled, endpoint 0.
    da(1'b1, 16'hff08, 8'h8c);
    pk(2'd1, 1'b0, 7'd1, HS_STALL, 11'h000, 1'b0);
    dc(16'hff08, 8'h8c);
    da(1'b1, 16'hff08, 8'h04);
    pk(2'd1, 1'b0, 7'd1, HS_NONE, 11'h000, 1'b0);
    pk(2'd0, 1'b0, 7'd1, HS_NONE, 11'h000, 1'b0);
    // Double-buffered endpoint 2, completion masked off.
    da(1'b1, 16'hff10, 8'hb4);
    da(1'b1, 16'hff15, 8'h21);
    da(1'b1, 16'hff16, 8'h00);
    da(1'b1, 16'hff11, 8'h30);
    da(1'b1, 16'hff12, 8'h00);
    pk(2'd2, 1'b1, 7'd7, HS_ACK, 11'h108, 1'b1);
    dc(16'hff16, 8'h87);
    pk(2'd2, 1'b0, 7'd2, HS_ACK, 11'h180, 1'b1);
    dc(16'hff12, 8'h82);
    dc(16'hff10, 8'hb4);
    ck(irq, 1'b0);
    ap(1'b0, REG_IRQ_STATUS, 32'h0);
    ck(rd, 32'ha);
    // Toggle set without double buffering still uses X.
    da(1'b1, 16'hff18, 8'ha0);
    da(1'b1, 16'hff19, 8'h05);
    da(1'b1, 16'hff1a, 8'h00);
    pk(2'd3, 1'b1, 7'd4, HS_ACK, 11'h028, 1'b1);
    // Endpoint 3 has its completion enable clear, so only the access bit is set.
    ap(1'b0, REG_IRQ_STATUS, 32'h0);
    ck(rd, 32'h8);
    ck(irq, 1'b0);
    results();
  end
endmodule
